//--- rtl/pcgc_defines.vh
// Purpose: constants for the power and clock gating controller
// Assumes: 125 MHz mclk, 8-bit register address, 32-bit data
// Notes:   offsets are byte addresses of 32-bit words
`ifndef PCGC_DEFINES_VH
`define PCGC_DEFINES_VH

// Register offsets
`define PCGC_OFS_PERIPH      8'h00
`define PCGC_OFS_ACCEL       8'h04
`define PCGC_OFS_DSPCLK      8'h08
`define PCGC_OFS_DSPPWR      8'h0c
`define PCGC_OFS_WAKE        8'h10
`define PCGC_OFS_BOOTINFO    8'h14
`define PCGC_OFS_RF          8'h18
`define PCGC_OFS_IDLE        8'h1c
`define PCGC_OFS_STATUS      8'h20

// Widths
`define PCGC_NPERIPH         16
`define PCGC_NCORE           3
`define PCGC_NENGINE         4

// Accelerator control fields
`define PCGC_ACC_ENG_LSB     0
`define PCGC_ACC_CLK_BIT     4
`define PCGC_ACC_PWR_BIT     5
`define PCGC_ACC_CFG_BIT     6
// DSP clock fields
`define PCGC_DCK_SRC_BIT     0
`define PCGC_DCK_DIV_LSB     4
`define PCGC_DCK_DIV_MSB     7
// DSP power fields
`define PCGC_DPW_ON_BIT      0
`define PCGC_DPW_UP_BIT      1
`define PCGC_DPW_L1_BIT      2
// Radio boot info word: dynamic clocking bit
`define PCGC_BOOT_DYN_BIT    3
// RF control fields
`define PCGC_RF_PLL_BIT      0
`define PCGC_RF_TXOFF_BIT    1
`define PCGC_RF_LP_BIT       2
`define PCGC_RF_IFBW_LSB     16
`define PCGC_RF_IFBW_MSB     31

// Reset values
`define PCGC_RST_PERIPH      16'hffff
`define PCGC_RST_ACCEL       7'h3f
`define PCGC_RST_DSPCLK      8'h00
`define PCGC_RST_RF          32'h0000_0001

// Timing
`define PCGC_CLK_NS          8
`define PCGC_DSP_RST_NS      1000
`define PCGC_DSP_RST_CYC     ((`PCGC_DSP_RST_NS + `PCGC_CLK_NS - 1) / `PCGC_CLK_NS)
`define PCGC_MIN_IDLE_NS     2000
`define PCGC_MIN_IDLE_CYC    ((`PCGC_MIN_IDLE_NS + `PCGC_CLK_NS - 1) / `PCGC_CLK_NS)
// IF bandwidth limit for converter low power, in kHz
`define PCGC_IFBW_MAX_KHZ    16'h1d4c

`endif

//--- rtl/pcgc_ctrl.v
// Purpose: clock gate, frequency select and power switch control
// Assumes: all inputs synchronous to mclk; gate cells sit outside
// Notes:   enables are active high; clocks themselves are not made here
`timescale 1ns/1ps
`default_nettype none
`include "pcgc_defines.vh"

// How it works
// - one clock enable per peripheral instance
// - wait instruction gates core, interrupt ungates
// - four accelerator engine clock gates, software set
// - DSP clock reducible to crystal, still clocked
// - DSP slowed by divider or source select
// - boot info bit three enables dynamic clocking
// - idle radio core runs from crystal clock
// - tick timer reserved for radio core
// - accelerator switch; config lost when off
// - dedicated DSP core power switch
// - DSP power down loses level-one memory
// - level-two memory retained while DSP off
// - DSP restarts at reset vector on power-up
// - wake timer expiry restores DSP power
// - PLL and synth held on in bursts
// - RF circuits off only in long idle
// - converter low power only below 7.5MHz
module pcgc_ctrl (
    input  wire        mclk,
    input  wire        reset_n,
    input  wire [7:0]  regAddr,
    input  wire [31:0] regWdata,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdata,
    input  wire [2:0]  coreWfi,
    input  wire        anyIrq,
    input  wire        radioIdle,
    input  wire        chirpActive,
    input  wire        burstActive,
    output wire [15:0] periphClkEn,
    output wire [2:0]  coreClkEn,
    output wire [3:0]  engineClkEn,
    output wire        accelClkEn,
    output wire        accelPwrEn,
    output wire        accelRst_n,
    output wire        dspClkSelXtal,
    output wire [3:0]  dspClkDiv,
    output wire        dspPwrEn,
    output wire        dspRst_n,
    output wire        l1Invalidate,
    output wire        l2Retain,
    output wire        dspWakeIrq,
    output wire        radioClkSelXtal,
    output wire        tickTimerToRadio,
    output wire        pllSynthEn,
    output wire        rfCircuitsOff,
    output wire        adcLowPower
);

    localparam integer RST_CYC_I = `PCGC_DSP_RST_CYC;
    localparam [9:0]   RST_CYC   = RST_CYC_I[9:0]; // Cut on purpose, count fits ten bits
    localparam [31:0] MIN_IDLE = `PCGC_MIN_IDLE_CYC;

    // Power sequence states for the DSP core, one-hot
    localparam [3:0] ST_ON    = 4'h1;
    localparam [3:0] ST_OFF   = 4'h2;
    localparam [3:0] ST_RESET = 4'h4;
    localparam [3:0] ST_WAIT  = 4'h8;

    // Control state, one flop word per register
    reg  [15:0] periphEn_r;
    reg  [2:0]  coreGated_r;
    reg  [6:0]  accel_r;
    reg  [7:0]  dspClk_r;
    reg         dspOnReq_r;
    reg         l1Lost_r;
    reg  [31:0] wakeCnt_r;
    reg         wakePulse_r;
    reg  [31:0] bootInfo_r;
    reg  [31:0] rf_r;
    reg  [31:0] idleLen_r;
    reg  [3:0]  dspState_r;
    reg  [3:0]  dspState_nxt;
    reg  [9:0]  rstCnt_r;
    reg         l1Pulse_r;
    reg  [31:0] rdData_nxt;

    // Exact match only; an alias could let a stray write drop a supply
    function addrHit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            addrHit = (addr == ofs);
        end
    endfunction

    // Write strobes, one per register
    wire        wrPeriph = regWr && addrHit(regAddr, `PCGC_OFS_PERIPH);
    wire        wrAccel  = regWr && addrHit(regAddr, `PCGC_OFS_ACCEL);
    wire        wrDspClk = regWr && addrHit(regAddr, `PCGC_OFS_DSPCLK);
    wire        wrDspPwr = regWr && addrHit(regAddr, `PCGC_OFS_DSPPWR);
    wire        wrWake   = regWr && addrHit(regAddr, `PCGC_OFS_WAKE);
    wire        wrBoot   = regWr && addrHit(regAddr, `PCGC_OFS_BOOTINFO);
    wire        wrRf     = regWr && addrHit(regAddr, `PCGC_OFS_RF);
    wire        wrIdle   = regWr && addrHit(regAddr, `PCGC_OFS_IDLE);
    wire        wakeFire = (wakeCnt_r == 32'h0000_0001);
    wire        dynClkEn = bootInfo_r[`PCGC_BOOT_DYN_BIT];
    wire [15:0] ifBw     = rf_r[`PCGC_RF_IFBW_MSB:`PCGC_RF_IFBW_LSB];

    // Status word shared by the status read
    function [31:0] statusWord;
        input [2:0] gated;
        input [3:0] st;
        input       dyn;
        input       cfg;
        begin
            statusWord = {20'h00000, cfg, dyn, st, 3'h0, gated};
        end
    endfunction

    // Peripheral gates; default all running after reset
    always @(posedge mclk) begin
        if (!reset_n) begin
            periphEn_r <= `PCGC_RST_PERIPH;
        end else if (wrPeriph) begin
            periphEn_r <= regWdata[15:0];
        end
    end

    // Core gating: wake wins over a new wait so no interrupt is missed
    always @(posedge mclk) begin
        if (!reset_n) begin
            coreGated_r <= 3'h0;
        end else if (anyIrq) begin
            coreGated_r <= 3'h0;
        end else begin
            coreGated_r <= coreGated_r | coreWfi;
        end
    end

    // Accelerator control; config flag drops whenever the supply is off
    always @(posedge mclk) begin
        if (!reset_n) begin
            accel_r <= `PCGC_RST_ACCEL;
        end else if (wrAccel) begin
            accel_r[5:0] <= regWdata[5:0];
            accel_r[`PCGC_ACC_CFG_BIT] <= regWdata[`PCGC_ACC_PWR_BIT] &
                                          regWdata[`PCGC_ACC_CFG_BIT];
        end else if (!accel_r[`PCGC_ACC_PWR_BIT]) begin
            accel_r[`PCGC_ACC_CFG_BIT] <= 1'b0;
        end
    end

    // DSP clock source and divider, written only by software
    always @(posedge mclk) begin
        if (!reset_n) begin
            dspClk_r <= `PCGC_RST_DSPCLK;
        end else if (wrDspClk) begin
            dspClk_r <= regWdata[7:0];
        end
    end

    // Wake timer counts down; expiry requests DSP power
    always @(posedge mclk) begin
        if (!reset_n) begin
            wakeCnt_r   <= 32'h0000_0000;
            wakePulse_r <= 1'b0;
        end else begin
            wakePulse_r <= wakeFire;
            if (wrWake) begin
                wakeCnt_r <= regWdata;
            end else if (wakeCnt_r != 32'h0000_0000) begin
                wakeCnt_r <= wakeCnt_r - 32'h0000_0001;
            end
        end
    end

    // DSP power request; the timer's set beats a software clear
    always @(posedge mclk) begin
        if (!reset_n) begin
            dspOnReq_r <= 1'b1;
        end else if (wakeFire) begin
            dspOnReq_r <= 1'b1;
        end else if (wrDspPwr) begin
            dspOnReq_r <= regWdata[`PCGC_DPW_ON_BIT];
        end
    end

    // Power sequence next state
    always @* begin
        dspState_nxt = dspState_r;
        case (dspState_r)
            ST_ON: begin
                if (!dspOnReq_r) begin
                    dspState_nxt = ST_OFF;
                end
            end
            ST_OFF: begin
                if (dspOnReq_r) begin
                    dspState_nxt = ST_RESET;
                end
            end
            ST_RESET: begin
                if (rstCnt_r == RST_CYC) begin
                    dspState_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                dspState_nxt = ST_ON;
            end
            default: begin
                dspState_nxt = ST_ON;
            end
        endcase
    end

    // Held reset after power-up forces a fresh start, not a resume
    always @(posedge mclk) begin
        if (!reset_n) begin
            dspState_r <= ST_ON;
            rstCnt_r   <= 10'h000;
            l1Lost_r   <= 1'b0;
            l1Pulse_r  <= 1'b0;
        end else begin
            dspState_r <= dspState_nxt;
            l1Pulse_r  <= (dspState_r == ST_OFF) && dspOnReq_r;
            if (dspState_r == ST_RESET) begin
                rstCnt_r <= rstCnt_r + 10'h001;
            end else begin
                rstCnt_r <= 10'h000;
            end
            if (dspState_r == ST_OFF) begin
                l1Lost_r <= 1'b1;
            end else if (wrDspPwr && regWdata[`PCGC_DPW_L1_BIT]) begin
                l1Lost_r <= 1'b0;
            end
        end
    end

    // Radio boot word; all bits kept, only bit three acts here
    always @(posedge mclk) begin
        if (!reset_n) begin
            bootInfo_r <= 32'h0000_0000;
        end else if (wrBoot) begin
            bootInfo_r <= regWdata;
        end
    end

    // RF control; PLL request set at reset so the synth starts running
    always @(posedge mclk) begin
        if (!reset_n) begin
            rf_r <= `PCGC_RST_RF;
        end else if (wrRf) begin
            rf_r <= regWdata;
        end
    end

    // Inter-chirp idle length in mclk cycles, set per chirp profile
    always @(posedge mclk) begin
        if (!reset_n) begin
            idleLen_r <= 32'h0000_0000;
        end else if (wrIdle) begin
            idleLen_r <= regWdata;
        end
    end

    // Read mux; unmapped addresses answer zero
    always @* begin
        rdData_nxt = 32'h0000_0000;
        if (addrHit(regAddr, `PCGC_OFS_PERIPH)) begin
            rdData_nxt = {16'h0000, periphEn_r};
        end else if (addrHit(regAddr, `PCGC_OFS_ACCEL)) begin
            rdData_nxt = {25'h0000000, accel_r};
        end else if (addrHit(regAddr, `PCGC_OFS_DSPCLK)) begin
            rdData_nxt = {24'h000000, dspClk_r};
        end else if (addrHit(regAddr, `PCGC_OFS_DSPPWR)) begin
            rdData_nxt = {29'h00000000, l1Lost_r, (dspState_r == ST_ON), dspOnReq_r};
        end else if (addrHit(regAddr, `PCGC_OFS_WAKE)) begin
            rdData_nxt = wakeCnt_r;
        end else if (addrHit(regAddr, `PCGC_OFS_BOOTINFO)) begin
            rdData_nxt = bootInfo_r;
        end else if (addrHit(regAddr, `PCGC_OFS_RF)) begin
            rdData_nxt = rf_r;
        end else if (addrHit(regAddr, `PCGC_OFS_IDLE)) begin
            rdData_nxt = idleLen_r;
        end else if (addrHit(regAddr, `PCGC_OFS_STATUS)) begin
            rdData_nxt = statusWord(coreGated_r, dspState_r, dynClkEn,
                                    accel_r[`PCGC_ACC_CFG_BIT]);
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge mclk) begin
        if (!reset_n) begin
            regRdata <= 32'h0000_0000;
        end else if (regRd) begin
            regRdata <= rdData_nxt;
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end

    // Gate enables
    assign periphClkEn = periphEn_r;
    assign coreClkEn   = ~coreGated_r;
    // Engine gates only matter while the accelerator clock runs
    assign engineClkEn = accel_r[3:0] & {4{accelClkEn}};
    // Software gating relied on here: no hidden frame-based ungate
    assign accelClkEn  = accel_r[`PCGC_ACC_CLK_BIT] & accel_r[`PCGC_ACC_PWR_BIT];
    assign accelPwrEn  = accel_r[`PCGC_ACC_PWR_BIT];
    assign accelRst_n  = accel_r[`PCGC_ACC_PWR_BIT];

    // DSP clock: crystal select keeps it clocked, only slower
    assign dspClkSelXtal = dspClk_r[`PCGC_DCK_SRC_BIT];
    assign dspClkDiv     = dspClk_r[`PCGC_DCK_DIV_MSB:`PCGC_DCK_DIV_LSB];

    // DSP power switch and restart
    assign dspPwrEn     = (dspState_r != ST_OFF);
    // Reset lets go in WAIT, a cycle before ON shows in status
    assign dspRst_n     = (dspState_r == ST_ON) || (dspState_r == ST_WAIT);
    // Level-one lines are gone after the outage; cache must drop them
    assign l1Invalidate = l1Pulse_r;
    // Level-two array keeps its own supply across core power-down
    assign l2Retain     = 1'b1;
    assign dspWakeIrq   = wakePulse_r;

    // Radio core dynamic clocking; source config assumed set before unhalt
    assign radioClkSelXtal  = dynClkEn & radioIdle;
    assign tickTimerToRadio = dynClkEn;

    // RF power: PLL forced on in bursts, RF off only in long gaps
    assign pllSynthEn    = rf_r[`PCGC_RF_PLL_BIT] | chirpActive | burstActive;
    // Short gaps keep the front end biased; a restart would overrun them
    assign rfCircuitsOff = rf_r[`PCGC_RF_TXOFF_BIT] & burstActive & ~chirpActive &
                           (idleLen_r >= MIN_IDLE);
    assign adcLowPower   = rf_r[`PCGC_RF_LP_BIT] & (ifBw < `PCGC_IFBW_MAX_KHZ);

endmodule // pcgc_ctrl
`default_nettype wire

//--- tb/pcgc_ctrl_chk.sv
// Purpose: port-level checks of the gating controller
// Assumes: one mclk domain, synchronous active-low reset
// Notes:   bound into every pcgc_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module pcgc_ctrl_chk (
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire logic [2:0] coreWfi,
    input wire logic       anyIrq,
    input wire logic       radioIdle,
    input wire logic       chirpActive,
    input wire logic       burstActive,
    input wire logic [2:0] coreClkEn,
    input wire logic [3:0] engineClkEn,
    input wire logic       accelClkEn,
    input wire logic       accelPwrEn,
    input wire logic       accelRst_n,
    input wire logic       dspPwrEn,
    input wire logic       dspRst_n,
    input wire logic       l2Retain,
    input wire logic       dspWakeIrq,
    input wire logic       radioClkSelXtal,
    input wire logic       tickTimerToRadio,
    input wire logic       pllSynthEn,
    input wire logic       rfCircuitsOff
);
    // Every check shares the one clock and its reset
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_core_gate: assert property (coreWfi[0] && !anyIrq |=> !coreClkEn[0])
        else $error("core clock not gated after wait");
    a_irq_ungate: assert property (anyIrq |=> coreClkEn == 3'h7)
        else $error("interrupt did not ungate cores");
    a_engine_off: assert property (!accelClkEn |-> engineClkEn == 4'h0)
        else $error("engine clock runs with accelerator gated");
    a_accel_dark: assert property (!accelPwrEn |-> !accelRst_n && !accelClkEn)
        else $error("unpowered accelerator not held");
    a_radio_crystal_clock: assert property (radioClkSelXtal == (tickTimerToRadio && radioIdle))
        else $error("radio clock source wrong");
    a_pll_hold: assert property (chirpActive || burstActive |-> pllSynthEn)
        else $error("synthesizer off inside burst");
    a_rf_chirp: assert property (chirpActive |-> !rfCircuitsOff)
        else $error("front end off during chirp");
    a_l2_kept: assert property (l2Retain)
        else $error("second level memory not retained");
    a_dsp_restart: assert property ($rose(dspPwrEn) |-> !dspRst_n [*8])
        else $error("core left reset too soon");
    a_wake_power: assert property (dspWakeIrq |-> ##[0:2] dspPwrEn)
        else $error("wake did not restore power");
endmodule // pcgc_ctrl_chk
bind pcgc_ctrl pcgc_ctrl_chk u_chk (.mclk, .reset_n, .coreWfi, .anyIrq, .radioIdle,
    .chirpActive, .burstActive, .coreClkEn, .engineClkEn, .accelClkEn, .accelPwrEn,
    .accelRst_n, .dspPwrEn, .dspRst_n, .l2Retain, .dspWakeIrq, .radioClkSelXtal,
    .tickTimerToRadio, .pllSynthEn, .rfCircuitsOff);
`default_nettype wire

//--- tb/pcgc_cpu_model.sv
// Purpose: processor cores and interrupt source facing the controller
// Assumes: commands from the bench arrive just after mclk edges
// Notes:   interrupt pends until every core clock runs again
`timescale 1ns/1ps
`default_nettype none
module pcgc_cpu_model (
    input  wire logic       mclk,
    input  wire logic [2:0] wfiCmd,
    input  wire logic       irqCmd,
    input  wire logic [2:0] coreClkEn,
    output var  logic [2:0] coreWfi,
    output var  logic       anyIrq
);
    initial coreWfi = 3'h0;
    initial anyIrq = 1'b0;
    // Pending interrupt is held, a lone pulse could be missed by a sleeping core
    always @(posedge mclk) begin
        coreWfi <= wfiCmd;
        if (irqCmd)
            anyIrq <= 1'b1;
        else if (coreClkEn == 3'h7)
            anyIrq <= 1'b0;
    end
endmodule // pcgc_cpu_model
`default_nettype wire

//--- tb/tb_power_clock_gating_control.sv
// Purpose: directed register and pin tests of the gating controller
// Assumes: 8 ns mclk, register port answers reads one cycle later
// Notes:   expected values come from the documented field layout
`timescale 1ns/1ps
`default_nettype none
module tb_power_clock_gating_control;
    logic mclk = 1'b0, reset_n = 1'b0, regWr = 1'b0, regRd = 1'b0, irqCmd = 1'b0;
    logic radioIdle = 1'b1, chirpActive = 1'b0, burstActive = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic [2:0] wfiCmd = 3'h0, coreWfi, coreClkEn;
    logic [15:0] periphClkEn;
    logic [3:0] engineClkEn, dspClkDiv;
    logic anyIrq, accelClkEn, accelPwrEn, accelRst_n, dspClkSelXtal, dspPwrEn, dspRst_n;
    logic l1Invalidate, l2Retain, dspWakeIrq, radioClkSelXtal, tickTimerToRadio;
    logic pllSynthEn, rfCircuitsOff, adcLowPower;
    int bad_count = 0;
    int samples_checked = 0;
    pcgc_ctrl DUT (.mclk, .reset_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .coreWfi, .anyIrq, .radioIdle, .chirpActive, .burstActive, .periphClkEn,
        .coreClkEn, .engineClkEn, .accelClkEn, .accelPwrEn, .accelRst_n, .dspClkSelXtal,
        .dspClkDiv, .dspPwrEn, .dspRst_n, .l1Invalidate, .l2Retain, .dspWakeIrq,
        .radioClkSelXtal, .tickTimerToRadio, .pllSynthEn, .rfCircuitsOff, .adcLowPower);
    pcgc_cpu_model cpu (.mclk, .wfiCmd, .irqCmd, .coreClkEn, .coreWfi, .anyIrq);
    // 125 MHz clock
    always #4 mclk = ~mclk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        chk(regRdata, exp);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Bounded wait for the wake pulse (sel 0) or reset release (sel 1)
    task automatic waitSig(input int sel);
        for (int n = 0; n < 400; n++) begin
            @(posedge mclk);
            #1;
            if ((sel == 0 ? dspWakeIrq : dspRst_n) === 1'b1)
                return;
        end
        bad_count++;
        tally_and_finish();
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        rd(8'h00, 32'h0000ffff);
        wr(8'h00, 32'h00005a5a);
        chk(periphClkEn, 16'h5a5a);
        rd(8'hfc, 32'h0);
        @(posedge mclk) wfiCmd <= 3'h1;
        @(posedge mclk) wfiCmd <= 3'h0;
        repeat (2) @(posedge mclk);
        #1 chk(coreClkEn, 3'h6);
        rd(8'h20, 32'h41);
        @(posedge mclk) irqCmd <= 1'b1;
        @(posedge mclk) irqCmd <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk(coreClkEn, 3'h7);
        wr(8'h04, 32'h25);
        chk({engineClkEn, accelClkEn}, 5'h0);
        wr(8'h04, 32'h35);
        chk(engineClkEn, 4'h5);
        wr(8'h04, 32'h0);
        chk({accelPwrEn, accelRst_n}, 2'h0);
        wr(8'h04, 32'h70);
        rd(8'h04, 32'h70);
        rd(8'h20, 32'h840);
        wr(8'h04, 32'h40);
        rd(8'h04, 32'h0);
        wr(8'h08, 32'h51);
        chk({dspClkSelXtal, dspClkDiv}, 5'h15);
        rd(8'h08, 32'h51);
        wr(8'h14, 32'h08);
        chk({radioClkSelXtal, tickTimerToRadio}, 2'h3);
        rd(8'h14, 32'h8);
        rd(8'h20, 32'h440);
        @(posedge mclk) radioIdle <= 1'b0;
        #1 chk(radioClkSelXtal, 1'b0);
        wr(8'h14, 32'h0);
        chk(tickTimerToRadio, 1'b0);
        wr(8'h0c, 32'h0);
        repeat (2) @(posedge mclk);
        #1 chk({dspPwrEn, dspRst_n}, 2'h0);
        rd(8'h0c, 32'h4);
        rd(8'h20, 32'h80);
        wr(8'h10, 32'h3);
        waitSig(0);
        @(posedge mclk);
        #1 chk(l1Invalidate, 1'b1);
        repeat (99) @(posedge mclk);
        #1 chk({dspPwrEn, dspRst_n, l1Invalidate}, 3'h4);
        waitSig(1);
        chk(l2Retain, 1'b1);
        rd(8'h0c, 32'h7);
        rd(8'h10, 32'h0);
        wr(8'h0c, 32'h5);
        rd(8'h0c, 32'h3);
        wr(8'h1c, 32'hfa);
        rd(8'h1c, 32'hfa);
        wr(8'h18, 32'h1d4b0006);
        chk(adcLowPower, 1'b1);
        rd(8'h18, 32'h1d4b0006);
        @(posedge mclk) burstActive <= 1'b1;
        #1 chk({rfCircuitsOff, pllSynthEn}, 2'h3);
        @(posedge mclk) chirpActive <= 1'b1;
        #1 chk({rfCircuitsOff, pllSynthEn}, 2'h1);
        @(posedge mclk) chirpActive <= 1'b0;
        wr(8'h1c, 32'hf9);
        chk(rfCircuitsOff, 1'b0);
        @(posedge mclk) burstActive <= 1'b0;
        #1 chk(pllSynthEn, 1'b0);
        wr(8'h18, 32'h1d4c0006);
        chk(adcLowPower, 1'b0);
        tally_and_finish();
    end
endmodule // tb_power_clock_gating_control
`default_nettype wire
